// *** pkg/icm_pkg.sv ***
// constants, types and register map of the collision-checking i2c master
package icm_pkg;
    // avalon byte offsets, one word per register
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_BUFFER = 8'h0c;
    localparam logic [7:0] OFS_ADDR = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
    // control one fields
    localparam int CT1_ENABLE = 5;
    localparam int CT1_MODE_LO = 0;
    localparam logic [3:0] MODE_MASTER = 4'h8;
    localparam logic [3:0] MODE_SLAVE_MASKED = 4'h6;
    // control two fields
    localparam int CT2_START = 0;
    localparam int CT2_RSTART = 1;
    localparam int CT2_STOP = 2;
    localparam int CT2_ACK = 4;
    // status fields
    localparam int STA_START_SEEN = 3;
    localparam int STA_STOP_SEEN = 4;
    // interrupt status and mask fields
    localparam int IRQ_SERIAL = 0;
    localparam int IRQ_COLLISION = 1;
    localparam int IRQ_BITS = 2;
    // reload field of the address register
    localparam int RELOAD_HI = 6;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [6:0] RST_BRG = 7'h00;

    typedef enum {
        SEQ_IDLE,
        SEQ_RS_SDA,
        SEQ_RS_CNT1,
        SEQ_RS_SCL,
        SEQ_RS_CNT2,
        SEQ_RS_CNT3,
        SEQ_SP_SDA,
        SEQ_SP_SCL,
        SEQ_SP_CNT1,
        SEQ_SP_CNT2
    } icm_seq_t;

    // synchronised samples of the two bus lines and the previous scl sample
    typedef struct packed {
        logic sda_s1;
        logic sda_s2;
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
    } icm_lines_t;

    typedef struct packed {
        icm_seq_t seq;
        logic [6:0] baud_rate_generator;
        icm_lines_t ln;
        logic sda_drv;
        logic scl_drv;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] stat;
        logic [7:0] buff;
        logic [7:0] addr;
        logic [7:0] msk;
        logic [IRQ_BITS-1:0] ist;
        logic [IRQ_BITS-1:0] imsk;
        logic ack;
        logic [31:0] rdata;
    } icm_state_t;
endpackage

// *** hdl/icm_master.sv ***
// i2c master repeated start and stop sequencer with bus collision detection
// Behaviour
// - repeated start: sda low when scl rises is a collision.
// - repeated start: scl falling before we drive sda low is a collision.
// - after sda floats high, load reload bits 6:0, count, release scl, sample sda.
// - repeated start: sda low once scl reads high flags a collision.
// - sda high then reload and count; early sda fall is no collision.
// - scl fall during that count before sda driven is a collision.
// - count ends lines high: drive sda low, count again, then drive scl low.
// - stop: drive sda low, release scl, on scl high load and count.
// - stop: sda still low after count with sda released is a collision.
// - stop: scl low after release and before sda high is a collision.
// - address register is slave address or, in master mode, reload value.
// - mask register shares the address offset, reachable in masked slave mode.
// - in slave mode control two bits 5:1 are address mask bits.
// - any collision sets the collision flag and idles the port.
// - collision releases both lines and clears the sequence enable bits.
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module icm_master (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // serial data line, open drain
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    // serial clock line, open drain
    input wire logic serial_clock_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe,
    // interrupt
    output logic irq
);
    icm_pkg::icm_state_t s;
    icm_pkg::icm_state_t next_s;

    logic sda;
    logic scl;
    logic scl_rise;
    logic scl_fall;
    logic master_on;
    logic masked_slave;
    logic coll;
    logic [icm_pkg::IRQ_BITS-1:0] ev;
    logic [icm_pkg::IRQ_BITS-1:0] clr;
    logic wr_lane;
    logic [7:0] rd_byte;

    // only the second flop of each synchroniser is looked at
    assign sda = s.ln.sda_s2;
    assign scl = s.ln.scl_s2;
    assign scl_rise = scl & ~s.ln.scl_d;
    assign scl_fall = ~scl & s.ln.scl_d;

    // mode decode from control one
    assign master_on = s.ctrl1[icm_pkg::CT1_ENABLE] &&
        (s.ctrl1[icm_pkg::CT1_MODE_LO +: 4] == icm_pkg::MODE_MASTER);
    assign masked_slave = s.ctrl1[icm_pkg::CT1_ENABLE] &&
        (s.ctrl1[icm_pkg::CT1_MODE_LO +: 4] == icm_pkg::MODE_SLAVE_MASKED);

    // handshake: every access waits until one cycle with ce high has passed
    assign waitrequest = (read | write) & ~s.ack;
    assign readdata = s.rdata;
    assign wr_lane = byteenable[0];

    // lines are open drain: only ever pulled low
    assign serial_data_line_out = 1'b0;
    assign serial_clock_line_out = 1'b0;
    assign serial_data_line_oe = s.sda_drv;
    assign serial_clock_line_oe = s.scl_drv;
    assign irq = |(s.ist & s.imsk);

    // read multiplexer, low byte only
    always_comb begin
        rd_byte = 8'h00;
        unique case (address)
            icm_pkg::OFS_CTRL_ONE: rd_byte = s.ctrl1;
            icm_pkg::OFS_CTRL_TWO: rd_byte = s.ctrl2;
            icm_pkg::OFS_STATUS: rd_byte = s.stat;
            icm_pkg::OFS_BUFFER: rd_byte = s.buff;
            icm_pkg::OFS_ADDR: begin
                // shared offset, the mask shows only in masked slave mode
                rd_byte = masked_slave ? s.msk : s.addr;
            end
            icm_pkg::OFS_IRQ_STAT: rd_byte = {6'h00, s.ist};
            icm_pkg::OFS_IRQ_MASK: rd_byte = {6'h00, s.imsk};
            default: rd_byte = 8'h00;
        endcase
    end

    // next state of the whole block
    always_comb begin
        next_s = s;
        coll = 1'b0;
        ev = '0;
        clr = '0;
        if (ce) begin
            // synchroniser chain and edge history
            next_s.ln.sda_s1 = serial_data_line_in;
            next_s.ln.sda_s2 = s.ln.sda_s1;
            next_s.ln.scl_s1 = serial_clock_line_in;
            next_s.ln.scl_s2 = s.ln.scl_s1;
            next_s.ln.scl_d = s.ln.scl_s2;

            // bus slave: capture read data, complete on the next edge
            if ((read | write) && !s.ack) begin
                next_s.ack = 1'b1;
                next_s.rdata = {24'h000000, rd_byte};
            end else if (s.ack) begin
                next_s.ack = 1'b0;
                if (read && address == icm_pkg::OFS_IRQ_STAT) begin
                    // clear only what was actually returned
                    clr = s.rdata[icm_pkg::IRQ_BITS-1:0];
                end
                if (write && wr_lane) begin
                    unique case (address)
                        icm_pkg::OFS_CTRL_ONE: begin
                            next_s.ctrl1 = writedata[7:0];
                        end
                        icm_pkg::OFS_CTRL_TWO: begin
                            // in slave mode bits 5:1 hold mask bits only
                            next_s.ctrl2 = writedata[7:0];
                        end
                        icm_pkg::OFS_BUFFER: begin
                            next_s.buff = writedata[7:0];
                        end
                        icm_pkg::OFS_ADDR: begin
                            if (masked_slave) begin
                                next_s.msk = writedata[7:0];
                            end else begin
                                next_s.addr = writedata[7:0];
                            end
                        end
                        icm_pkg::OFS_IRQ_MASK: begin
                            next_s.imsk = writedata[icm_pkg::IRQ_BITS-1:0];
                        end
                        default: begin
                            next_s.ctrl1 = next_s.ctrl1;
                        end
                    endcase
                end
            end

            // sequence engine, one baud tick per enabled cycle
            unique case (s.seq)
                icm_pkg::SEQ_IDLE: begin
                    // sequence bits act only in master mode, never in slave mode
                    if (master_on && s.ctrl2[icm_pkg::CT2_RSTART]) begin
                        next_s.sda_drv = 1'b0;
                        next_s.scl_drv = 1'b1;
                        next_s.stat[icm_pkg::STA_STOP_SEEN] = 1'b0;
                        next_s.seq = icm_pkg::SEQ_RS_SDA;
                    end else if (master_on && s.ctrl2[icm_pkg::CT2_STOP]) begin
                        next_s.sda_drv = 1'b1;
                        next_s.scl_drv = 1'b1;
                        next_s.seq = icm_pkg::SEQ_SP_SDA;
                    end
                end
                icm_pkg::SEQ_RS_SDA: begin
                    // sda released, wait for it to float high
                    if (sda) begin
                        next_s.baud_rate_generator = s.addr[icm_pkg::RELOAD_HI:0];
                        next_s.seq = icm_pkg::SEQ_RS_CNT1;
                    end
                end
                icm_pkg::SEQ_RS_CNT1: begin
                    if (s.baud_rate_generator == 7'h00) begin
                        next_s.scl_drv = 1'b0;
                        next_s.seq = icm_pkg::SEQ_RS_SCL;
                    end else begin
                        next_s.baud_rate_generator = s.baud_rate_generator - 7'h01;
                    end
                end
                icm_pkg::SEQ_RS_SCL: begin
                    // waits as long as a slave stretches the clock
                    if (scl) begin
                        if (!sda) begin
                            coll = 1'b1;
                        end else begin
                            next_s.baud_rate_generator = s.addr[icm_pkg::RELOAD_HI:0];
                            next_s.seq = icm_pkg::SEQ_RS_CNT2;
                        end
                    end
                end
                icm_pkg::SEQ_RS_CNT2: begin
                    // an early sda fall is another start, not a collision
                    if (scl_fall && !s.sda_drv) begin
                        coll = 1'b1;
                    end else if (s.baud_rate_generator == 7'h00) begin
                        next_s.sda_drv = 1'b1;
                        next_s.baud_rate_generator = s.addr[icm_pkg::RELOAD_HI:0];
                        next_s.seq = icm_pkg::SEQ_RS_CNT3;
                    end else begin
                        next_s.baud_rate_generator = s.baud_rate_generator - 7'h01;
                    end
                end
                icm_pkg::SEQ_RS_CNT3: begin
                    if (s.baud_rate_generator == 7'h00) begin
                        // scl is pulled low whatever its level
                        next_s.scl_drv = 1'b1;
                        next_s.ctrl2[icm_pkg::CT2_RSTART] = 1'b0;
                        next_s.stat[icm_pkg::STA_START_SEEN] = 1'b1;
                        ev[icm_pkg::IRQ_SERIAL] = 1'b1;
                        next_s.seq = icm_pkg::SEQ_IDLE;
                    end else begin
                        next_s.baud_rate_generator = s.baud_rate_generator - 7'h01;
                    end
                end
                icm_pkg::SEQ_SP_SDA: begin
                    if (!sda) begin
                        next_s.scl_drv = 1'b0;
                        next_s.seq = icm_pkg::SEQ_SP_SCL;
                    end
                end
                icm_pkg::SEQ_SP_SCL: begin
                    // clock arbitration: low here is a stretching slave
                    if (scl) begin
                        next_s.baud_rate_generator = s.addr[icm_pkg::RELOAD_HI:0];
                        next_s.seq = icm_pkg::SEQ_SP_CNT1;
                    end
                end
                icm_pkg::SEQ_SP_CNT1: begin
                    if (!scl) begin
                        coll = 1'b1;
                    end else if (s.baud_rate_generator == 7'h00) begin
                        next_s.sda_drv = 1'b0;
                        next_s.baud_rate_generator = s.addr[icm_pkg::RELOAD_HI:0];
                        next_s.seq = icm_pkg::SEQ_SP_CNT2;
                    end else begin
                        next_s.baud_rate_generator = s.baud_rate_generator - 7'h01;
                    end
                end
                icm_pkg::SEQ_SP_CNT2: begin
                    if (!scl && !sda) begin
                        coll = 1'b1;
                    end else if (s.baud_rate_generator == 7'h00) begin
                        if (!sda) begin
                            coll = 1'b1;
                        end else begin
                            next_s.stat[icm_pkg::STA_STOP_SEEN] = 1'b1;
                            next_s.stat[icm_pkg::STA_START_SEEN] = 1'b0;
                            next_s.ctrl2[icm_pkg::CT2_STOP] = 1'b0;
                            ev[icm_pkg::IRQ_SERIAL] = 1'b1;
                            next_s.seq = icm_pkg::SEQ_IDLE;
                        end
                    end else begin
                        next_s.baud_rate_generator = s.baud_rate_generator - 7'h01;
                    end
                end
            endcase

            // disabling the port mid sequence drops it silently
            if (!master_on && s.seq != icm_pkg::SEQ_IDLE) begin
                next_s.sda_drv = 1'b0;
                next_s.scl_drv = 1'b0;
                next_s.seq = icm_pkg::SEQ_IDLE;
            end

            // collision abort: lines free, enables cleared, port idle
            if (coll) begin
                ev[icm_pkg::IRQ_COLLISION] = 1'b1;
                next_s.sda_drv = 1'b0;
                next_s.scl_drv = 1'b0;
                next_s.ctrl2[icm_pkg::CT2_START] = 1'b0;
                next_s.ctrl2[icm_pkg::CT2_RSTART] = 1'b0;
                next_s.ctrl2[icm_pkg::CT2_STOP] = 1'b0;
                next_s.ctrl2[icm_pkg::CT2_ACK] = 1'b0;
                next_s.seq = icm_pkg::SEQ_IDLE;
            end

            // sticky flags: a new event wins over a read clear
            next_s.ist = (s.ist & ~clr) | ev;
        end
    end

    // single state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s.seq <= icm_pkg::SEQ_IDLE;
            s.baud_rate_generator <= icm_pkg::RST_BRG;
            s.ln <= '1;
            s.sda_drv <= 1'b0;
            s.scl_drv <= 1'b0;
            s.ctrl1 <= icm_pkg::RST_REG;
            s.ctrl2 <= icm_pkg::RST_REG;
            s.stat <= icm_pkg::RST_REG;
            s.buff <= icm_pkg::RST_REG;
            s.addr <= icm_pkg::RST_REG;
            s.msk <= icm_pkg::RST_MASK;
            s.ist <= '0;
            s.imsk <= '0;
            s.ack <= 1'b0;
            s.rdata <= 32'h00000000;
        end else begin
            s <= next_s;
        end
    end
endmodule

// *** sim/icm_bus_peer.sv ***
// other masters and slaves sharing the two open-drain lines
`timescale 1ns/1ps
module icm_bus_peer (
    // clock
    input wire logic sys_clk,
    // line enables of the master under test
    input wire logic sda_oe,
    input wire logic scl_oe,
    // what the other parties do
    input wire logic hold_sda_low,
    input wire logic hold_scl_low,
    input wire logic [3:0] stretch,
    // resolved wire levels
    output logic sda,
    output logic scl
);
    logic [3:0] rel_cnt = 4'hf;
    // cycles since the master let go of the clock, so a slow party can stretch it
    always_ff @(posedge sys_clk) begin
        rel_cnt <= scl_oe ? 4'h0 : (rel_cnt == 4'hf ? rel_cnt : rel_cnt + 4'h1);
    end
    // pull-ups: a released line reads high, any driver wins low
    assign sda = !(sda_oe || hold_sda_low);
    assign scl = !(scl_oe || hold_scl_low || rel_cnt < stretch);
endmodule

// *** sim/icm_checker.sv ***
// port-level checks of the repeated start and stop master
`timescale 1ns/1ps
module icm_checker (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // register bus
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // open-drain lines
    input wire logic serial_data_line_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe,
    input wire logic serial_clock_line_in,
    input wire logic serial_clock_line_out,
    input wire logic serial_clock_line_oe,
    // interrupt
    input wire logic irq
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // line events while the master drives neither line
    sequence s_sda_lost;
        $rose(serial_clock_line_in) && !serial_data_line_in && !serial_data_line_oe
            && !serial_clock_line_oe;
    endsequence
    sequence s_scl_lost;
        $fell(serial_clock_line_in) && !serial_data_line_oe && !serial_clock_line_oe;
    endsequence
    property p_wait_one;
        (read || write) && !waitrequest |=> waitrequest || !(read || write);
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");
    property p_wait_first;
        $rose(read || write) |-> waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("answer without capture");
    property p_rd_upper;
        read && !waitrequest |-> readdata[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_out_low;
        !serial_data_line_out && !serial_clock_line_out;
    endproperty
    a_out_low: assert property (p_out_low) else $error("line driven high");
    property p_sda_lost;
        s_sda_lost |=> !serial_data_line_oe [*8];
    endproperty
    a_sda_lost: assert property (p_sda_lost) else $error("data driven after lost");
    property p_scl_lost;
        s_scl_lost |=> (!serial_data_line_oe && !serial_clock_line_oe) [*8];
    endproperty
    a_scl_lost: assert property (p_scl_lost) else $error("lines driven after lost");
    property p_rs_finish;
        $rose(serial_data_line_oe) && !serial_clock_line_oe |-> ##[1:140] serial_clock_line_oe;
    endproperty
    a_rs_finish: assert property (p_rs_finish) else $error("clock not driven low");
    property p_sp_release;
        $fell(serial_data_line_oe) && !serial_clock_line_oe && serial_clock_line_in
            |-> $past(serial_clock_line_in, 3);
    endproperty
    a_sp_release: assert property (p_sp_release) else $error("data freed too soon");
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the repeated start and stop master
`timescale 1ns/1ps
bind icm_master icm_checker u_chk (.sys_clk, .arst_n, .ce, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .serial_data_line_in, .serial_data_line_out,
    .serial_data_line_oe, .serial_clock_line_in, .serial_clock_line_out,
    .serial_clock_line_oe, .irq);
module testbench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h1;
    logic [31:0] readdata;
    logic waitrequest, irq, hold_sda = 1'b0, hold_scl = 1'b0;
    logic serial_data_line_in, serial_data_line_out, serial_data_line_oe;
    logic serial_clock_line_in, serial_clock_line_out, serial_clock_line_oe;
    logic [3:0] stretch = 4'h0;
    logic [7:0] q;
    int fails = 0, comparisons = 0, k, rel_len, drv_len, t_rel, t_drv, tr[9], td[9];
    // command, wait kind, delay, line pulled, reload, stretch, irq status, irq mask
    logic [39:0] rows [9] = '{40'h02_1_0_0_83_3_1_3, 40'h04_1_0_0_83_0_1_3,
        40'h02_0_2_1_89_0_2_3, 40'h02_1_5_2_89_0_2_3, 40'h02_1_5_1_89_0_1_3,
        40'h04_1_0_0_89_0_1_3, 40'h04_2_1_1_89_0_2_3, 40'h04_1_5_2_89_0_2_3,
        40'h02_1_0_0_89_0_1_2};
    icm_master DUT (.sys_clk, .arst_n, .ce, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .serial_data_line_in, .serial_data_line_out,
        .serial_data_line_oe, .serial_clock_line_in, .serial_clock_line_out,
        .serial_clock_line_oe, .irq);
    icm_bus_peer u_peer (.sys_clk, .sda_oe(serial_data_line_oe), .scl_oe(serial_clock_line_oe),
        .hold_sda_low(hold_sda), .hold_scl_low(hold_scl), .stretch,
        .sda(serial_data_line_in), .scl(serial_clock_line_in));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // lengths of the released phase and of the data-low phase before the clock is pulled
    always @(posedge sys_clk) begin
        rel_len <= (serial_clock_line_oe || serial_data_line_oe) ? 0 : rel_len + 1;
        drv_len <= (serial_data_line_oe && !serial_clock_line_oe) ? drv_len + 1 : 0;
        if (serial_data_line_oe && !serial_clock_line_oe && rel_len != 0) t_rel <= rel_len;
        if (serial_clock_line_oe && drv_len != 0) t_drv <= drv_len;
    end
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h0, d};
        // no cycle count is assumed: only the watchdog ends a hung access
        @(posedge sys_clk);
        while (waitrequest !== 1'b0) @(posedge sys_clk);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task wait_oe(input logic clk_line, input logic v);
        int i;
        for (i = 0; i < 300; i++) begin
            if ((clk_line ? serial_clock_line_oe : serial_data_line_oe) === v) break;
            @(posedge sys_clk);
        end
        if (i == 300) fails++;
    endtask
    // one sequence, disturbed by the other party where the row says so
    task run_row(input logic [39:0] r);
        int i;
        acc(1'b1, icm_pkg::OFS_IRQ_MASK, {4'h0, r[3:0]});
        acc(1'b1, icm_pkg::OFS_ADDR, r[19:12]);
        stretch <= r[11:8];
        acc(1'b1, icm_pkg::OFS_CTRL_TWO, r[39:32]);
        wait_oe(r[31:28] != 4'h2, 1'b1);
        if (r[31:28] != 4'h0) wait_oe(r[31:28] != 4'h2, 1'b0);
        repeat (r[27:24]) @(posedge sys_clk);
        hold_sda <= r[23:20] == 4'h1;
        hold_scl <= r[23:20] == 4'h2;
        for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge sys_clk);
        chk("irq", {7'h0, irq}, {7'h0, |(r[7:4] & r[3:0])});
        acc(1'b0, icm_pkg::OFS_IRQ_STAT, 8'h00);
        chk("irq_status", q, {4'h0, r[7:4]});
        acc(1'b0, icm_pkg::OFS_CTRL_TWO, 8'h00);
        // the read clear lands on the closing edge, so irq is looked at one access later
        chk("irq_cleared", {7'h0, irq}, 8'h00);
        chk("control_two", q, 8'h00);
        chk("line_enables", {6'h0, serial_data_line_oe, serial_clock_line_oe},
            (r[39:32] == 8'h02 && r[7:4] == 4'h1) ? 8'h03 : 8'h00);
        acc(1'b0, icm_pkg::OFS_STATUS, 8'h00);
        if (r[7:4] == 4'h1) chk("status", q & (r[33] ? 8'h08 : 8'h10), r[33] ? 8'h08 : 8'h10);
        hold_sda <= 1'b0;
        hold_scl <= 1'b0;
    endtask
    task stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        // reset values, the last word unmapped
        for (k = 0; k < 6; k++) begin
            acc(1'b0, 8'(k * 4), 8'h00);
            chk("reset_value", q, 8'h00);
        end
        acc(1'b1, icm_pkg::OFS_CTRL_ONE, 8'h26);
        acc(1'b0, icm_pkg::OFS_ADDR, 8'h00);
        chk("address_mask", q, 8'hff);
        acc(1'b1, icm_pkg::OFS_ADDR, 8'h5a);
        acc(1'b1, icm_pkg::OFS_CTRL_ONE, 8'h28);
        acc(1'b0, icm_pkg::OFS_ADDR, 8'h00);
        chk("reload", q, 8'h00);
        acc(1'b1, icm_pkg::OFS_BUFFER, 8'ha5);
        acc(1'b0, icm_pkg::OFS_BUFFER, 8'h00);
        chk("buffer", q, 8'ha5);
        // slave mode: sequence bits are stored but start nothing
        acc(1'b1, icm_pkg::OFS_CTRL_ONE, 8'h26);
        acc(1'b1, icm_pkg::OFS_CTRL_TWO, 8'h02);
        repeat (40) @(posedge sys_clk);
        chk("slave_idle", {6'h0, serial_data_line_oe, serial_clock_line_oe}, 8'h00);
        acc(1'b0, icm_pkg::OFS_CTRL_TWO, 8'h00);
        chk("slave_bits", q, 8'h02);
        acc(1'b1, icm_pkg::OFS_CTRL_TWO, 8'h00);
        acc(1'b1, icm_pkg::OFS_CTRL_ONE, 8'h28);
        for (k = 0; k < 9; k++) begin
            run_row(rows[k]);
            tr[k] = t_rel;
            td[k] = t_drv;
        end
        // reload 9 against 3, the faster run also stretched by 3
        chk("release_span", 8'(tr[4] - tr[0]), 8'h03);
        chk("drive_span", 8'(td[4] - td[0]), 8'h06);
        // a low enable freezes a stop in its first step, lines stay pulled
        acc(1'b1, icm_pkg::OFS_CTRL_TWO, 8'h04);
        ce <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk("frozen", {6'h0, serial_data_line_oe, serial_clock_line_oe}, 8'h03);
        ce <= 1'b1;
        repeat (60) @(posedge sys_clk);
        chk("thawed", {6'h0, serial_data_line_oe, serial_clock_line_oe}, 8'h00);
        stop_test();
    end
endmodule
